// ### hdl/aapc_ctrl.v
// Audio converter path control: register file, update staging and data gating
`timescale 1ns/10ps
`include "aapc_defs.vh"

module aapc_ctrl (
  input  wire        clk_i,         // 100 MHz clock
  input  wire        rst_i,         // Synchronous reset, active high
  input  wire        wb_cyc_i,      // Wishbone cycle
  input  wire        wb_stb_i,      // Wishbone strobe
  input  wire        wb_we_i,       // Wishbone write enable
  input  wire [11:0] wb_adr_i,      // Byte address
  input  wire [3:0]  wb_sel_i,      // Byte lane selects
  input  wire [31:0] wb_dat_i,      // Write data
  output reg  [31:0] wb_dat_o,      // Read data
  output reg         wb_ack_o,      // Acknowledge
  output reg         wb_err_o,      // Unmapped address answer
  input  wire        dl_valid_i,    // Playback sample strobe
  input  wire [15:0] dl_left_i,     // Playback left sample
  input  wire [15:0] dl_right_i,    // Playback right sample
  output reg         dl_valid_o,    // Sample strobe to the DAC
  output reg  [15:0] dl_left_o,     // Left sample to the DAC
  output reg  [15:0] dl_right_o,    // Right sample to the DAC
  input  wire        ul_valid_i,    // Record sample strobe from the ADC
  input  wire [15:0] ul_left_i,     // Record left sample
  input  wire [15:0] ul_right_i,    // Record right sample
  output reg         ul_valid_o,    // Record sample strobe out
  output reg  [15:0] ul_left_o,     // Record left sample out
  output reg  [15:0] ul_right_o,    // Record right sample out
  output reg  [3:0]  playback_rate_code_o, // Applied playback rate
  output reg         record_rate_code_o,   // Applied record rate
  output wire [31:0] ul_src_ctrl_o, // Uplink source control to converter
  output wire [31:0] ul_mux_ctrl_o, // Uplink mux control
  output wire [31:0] tone_ctrl_o,   // Tone generator control
  output wire [31:0] dl_src_ctrl_o, // Downlink source control
  output wire [31:0] top_ctrl_o,    // Converter top control
  output wire [31:0] ser_ctrl_o,    // Serial audio output control
  output wire [15:0] test_ctrl_o,   // Converter test control
  output wire [15:0] ctone_ctrl_o,  // Converter tone control
  output wire        playback_path_on_o, // Playback path live
  output wire        record_path_on_o    // Record path live
);

  // ========================================================================
  // Register file
  reg [31:0] front_end_global_enable;
  reg [31:0] serial_audio_out_control;
  reg [31:0] downlink_source_control;
  reg [31:0] uplink_source_control;
  reg [31:0] uplink_source_mux;
  reg [31:0] converter_top_control;
  reg [31:0] converter_interface_global_enable;
  reg [31:0] tone_generator_control;
  reg [15:0] converter_path_enable;
  reg [15:0] converter_rate_select;
  reg [15:0] converter_test_control;
  reg [15:0] left_offset_value;
  reg [15:0] right_offset_value;
  reg [15:0] converter_tone_control;
  reg [15:0] offset_comp_enable;
  reg [15:0] converter_update_trigger;
  reg [15:0] left_offset_live;
  reg [15:0] right_offset_live;
  reg [1:0]  update_prev;

  wire       wr_req;
  wire       req;
  reg        hit;
  reg [31:0] rd_mux;

  // ========================================================================
  // Helper functions
  // Merge a write through byte lane selects
  function [31:0] aapc_merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    begin
      aapc_merge = {sel[3] ? dat[31:24] : old[31:24],
                    sel[2] ? dat[23:16] : old[23:16],
                    sel[1] ? dat[15:8]  : old[15:8],
                    sel[0] ? dat[7:0]   : old[7:0]};
    end
  endfunction

  // Saturating add of an S0.15 offset to a sample
  function [15:0] aapc_addsat;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s = {a[15], a} + {b[15], b};
      if (s[16] != s[15])
        aapc_addsat = s[16] ? 16'h8000 : 16'h7FFF;
      else
        aapc_addsat = s[15:0];
    end
  endfunction

  // Low-half merge for the 16-bit converter-side registers; the upper
  // lanes carry nothing for them
  function [15:0] wb_sel_merge16;
    input [15:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    begin
      wb_sel_merge16 = {sel[1] ? dat[15:8] : old[15:8],
                        sel[0] ? dat[7:0]  : old[7:0]};
    end
  endfunction

  assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wr_req = req & wb_we_i & hit;

  always @* begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      `AAPC_OFS_FE_EN:    rd_mux = front_end_global_enable;
      `AAPC_OFS_SER_OUT:  rd_mux = serial_audio_out_control;
      `AAPC_OFS_DL_SRC:   rd_mux = downlink_source_control;
      `AAPC_OFS_UL_SRC:   rd_mux = uplink_source_control;
      `AAPC_OFS_UL_MUX:   rd_mux = uplink_source_mux;
      `AAPC_OFS_TOP:      rd_mux = converter_top_control;
      `AAPC_OFS_IF_EN:    rd_mux = converter_interface_global_enable;
      `AAPC_OFS_TONE_GEN: rd_mux = tone_generator_control;
      `AAPC_OFS_PATH_EN:  rd_mux = {16'h0000, converter_path_enable};
      `AAPC_OFS_RATE:     rd_mux = {16'h0000, converter_rate_select};
      `AAPC_OFS_TEST:     rd_mux = {16'h0000, converter_test_control};
      `AAPC_OFS_LOFS:     rd_mux = {16'h0000, left_offset_value};
      `AAPC_OFS_ROFS:     rd_mux = {16'h0000, right_offset_value};
      `AAPC_OFS_CTONE:    rd_mux = {16'h0000, converter_tone_control};
      `AAPC_OFS_DCC_EN:   rd_mux = {16'h0000, offset_comp_enable};
      `AAPC_OFS_UPDATE:   rd_mux = {16'h0000, converter_update_trigger};
      // Applied state, read only
      `AAPC_OFS_STATUS:   rd_mux = {14'h0000, record_path_on_o,
                                    playback_path_on_o, 11'h000,
                                    record_rate_code_o,
                                    playback_rate_code_o};
      default:            hit = 1'b0;
    endcase
  end

  // ========================================================================
  // Wishbone slave: one wait-free answer, one cycle after the request
  // Registered ack: a write lands on the edge that raises ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= `AAPC_RST_32;
    end else begin
      wb_ack_o <= req & hit;
      wb_err_o <= req & ~hit;
      if (req & hit & ~wb_we_i)
        wb_dat_o <= rd_mux;
    end
  end

  // ========================================================================
  // Register writes; the status word is acknowledged but never written
  always @(posedge clk_i) begin
    if (rst_i) begin
      front_end_global_enable           <= `AAPC_RST_32;
      serial_audio_out_control          <= `AAPC_RST_32;
      downlink_source_control           <= `AAPC_RST_32;
      uplink_source_control             <= `AAPC_RST_32;
      uplink_source_mux                 <= `AAPC_RST_32;
      converter_top_control             <= `AAPC_RST_32;
      converter_interface_global_enable <= `AAPC_RST_32;
      tone_generator_control            <= `AAPC_RST_32;
      converter_path_enable             <= `AAPC_RST_16;
      converter_rate_select             <= `AAPC_RST_16;
      converter_test_control            <= `AAPC_RST_16;
      left_offset_value                 <= `AAPC_RST_16;
      right_offset_value                <= `AAPC_RST_16;
      converter_tone_control            <= `AAPC_RST_16;
      offset_comp_enable                <= `AAPC_RST_16;
      converter_update_trigger          <= `AAPC_RST_16;
    end else if (wr_req) begin
      case (wb_adr_i)
        `AAPC_OFS_FE_EN:    front_end_global_enable <=
          aapc_merge(front_end_global_enable, wb_dat_i, wb_sel_i);
        `AAPC_OFS_SER_OUT:  serial_audio_out_control <=
          aapc_merge(serial_audio_out_control, wb_dat_i, wb_sel_i);
        `AAPC_OFS_DL_SRC:   downlink_source_control <=
          aapc_merge(downlink_source_control, wb_dat_i, wb_sel_i);
        `AAPC_OFS_UL_SRC:   uplink_source_control <=
          aapc_merge(uplink_source_control, wb_dat_i, wb_sel_i);
        `AAPC_OFS_UL_MUX:   uplink_source_mux <=
          aapc_merge(uplink_source_mux, wb_dat_i, wb_sel_i);
        `AAPC_OFS_TOP:      converter_top_control <=
          aapc_merge(converter_top_control, wb_dat_i, wb_sel_i);
        `AAPC_OFS_IF_EN:    converter_interface_global_enable <=
          aapc_merge(converter_interface_global_enable, wb_dat_i,
                     wb_sel_i);
        `AAPC_OFS_TONE_GEN: tone_generator_control <=
          aapc_merge(tone_generator_control, wb_dat_i, wb_sel_i);
        `AAPC_OFS_PATH_EN:  converter_path_enable <=
          wb_sel_merge16(converter_path_enable, wb_dat_i, wb_sel_i);
        `AAPC_OFS_RATE:     converter_rate_select <=
          wb_sel_merge16(converter_rate_select, wb_dat_i, wb_sel_i);
        `AAPC_OFS_TEST:     converter_test_control <=
          wb_sel_merge16(converter_test_control, wb_dat_i, wb_sel_i);
        `AAPC_OFS_LOFS:     left_offset_value <=
          wb_sel_merge16(left_offset_value, wb_dat_i, wb_sel_i);
        `AAPC_OFS_ROFS:     right_offset_value <=
          wb_sel_merge16(right_offset_value, wb_dat_i, wb_sel_i);
        `AAPC_OFS_CTONE:    converter_tone_control <=
          wb_sel_merge16(converter_tone_control, wb_dat_i, wb_sel_i);
        `AAPC_OFS_DCC_EN:   offset_comp_enable <=
          wb_sel_merge16(offset_comp_enable, wb_dat_i, wb_sel_i);
        `AAPC_OFS_UPDATE:   converter_update_trigger <=
          wb_sel_merge16(converter_update_trigger, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Staged settings: applied only on a rising update bit, so a half-written
  // rate pair never reaches the converters
  // Update strobes fire on the 0-to-1 write of each trigger bit only
  wire rate_upd = converter_update_trigger[`AAPC_UPD_RATE_BIT] &
                  ~update_prev[0];
  wire dcc_upd  = converter_update_trigger[`AAPC_UPD_DCC_BIT] &
                  ~update_prev[1];

  always @(posedge clk_i) begin
    if (rst_i) begin
      update_prev          <= 2'b00;
      playback_rate_code_o <= 4'h0;
      record_rate_code_o   <= 1'b0;
      left_offset_live     <= `AAPC_RST_16;
      right_offset_live    <= `AAPC_RST_16;
    end else begin
      update_prev <= {converter_update_trigger[`AAPC_UPD_DCC_BIT],
                      converter_update_trigger[`AAPC_UPD_RATE_BIT]};
      if (rate_upd) begin
        playback_rate_code_o <= converter_rate_select[3:0];
        record_rate_code_o   <=
          converter_rate_select[`AAPC_RATE_UL_BIT];
      end
      if (dcc_upd) begin
        left_offset_live  <= left_offset_value;
        right_offset_live <= right_offset_value;
      end
    end
  end

  // ========================================================================
  // Path gating and sample handling
  wire fe_on   = front_end_global_enable[0];
  wire if_on   = converter_interface_global_enable[0];
  wire glob_on = fe_on & if_on;
  assign playback_path_on_o =
    glob_on & converter_path_enable[`AAPC_PATH_DL_BIT];
  assign record_path_on_o =
    glob_on & converter_path_enable[`AAPC_PATH_UL_BIT];

  wire dcc_on = offset_comp_enable[0];
  wire lmute  = converter_test_control[`AAPC_TEST_LMUTE_BIT];
  wire rmute  = converter_test_control[`AAPC_TEST_RMUTE_BIT];
  wire swap   = converter_test_control[`AAPC_TEST_SWAP_BIT];
  wire loopb  = converter_test_control[`AAPC_TEST_LOOP_BIT];

  // Mutes act after compensation so a muted channel is exactly zero
  reg [15:0] next_dl_left;
  reg [15:0] next_dl_right;
  always @* begin
    next_dl_left  = dcc_on ? aapc_addsat(dl_left_i, left_offset_live)
                           : dl_left_i;
    next_dl_right = dcc_on ? aapc_addsat(dl_right_i, right_offset_live)
                           : dl_right_i;
    if (lmute)
      next_dl_left = 16'h0000;
    if (rmute)
      next_dl_right = 16'h0000;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      dl_valid_o <= 1'b0;
      dl_left_o  <= 16'h0000;
      dl_right_o <= 16'h0000;
      ul_valid_o <= 1'b0;
      ul_left_o  <= 16'h0000;
      ul_right_o <= 16'h0000;
    end else begin
      dl_valid_o <= dl_valid_i & playback_path_on_o;
      if (dl_valid_i & playback_path_on_o) begin
        dl_left_o  <= next_dl_left;
        dl_right_o <= next_dl_right;
      end
      // Loopback feeds the processed playback sample into record
      // only while both paths are live; record-only setups lose it
      ul_valid_o <= record_path_on_o &
                    (loopb ? dl_valid_i & playback_path_on_o
                           : ul_valid_i);
      if (record_path_on_o & loopb & dl_valid_i & playback_path_on_o) begin
        ul_left_o  <= swap ? next_dl_right : next_dl_left;
        ul_right_o <= swap ? next_dl_left  : next_dl_right;
      end else if (record_path_on_o & ~loopb & ul_valid_i) begin
        ul_left_o  <= swap ? ul_right_i : ul_left_i;
        ul_right_o <= swap ? ul_left_i  : ul_right_i;
      end
    end
  end

  // Remaining configuration passes straight to the converter front end
  assign ul_src_ctrl_o = uplink_source_control;
  assign ul_mux_ctrl_o = uplink_source_mux;
  assign tone_ctrl_o   = tone_generator_control;
  assign dl_src_ctrl_o = downlink_source_control;
  assign top_ctrl_o    = converter_top_control;
  assign ser_ctrl_o    = serial_audio_out_control;
  assign test_ctrl_o   = converter_test_control;
  assign ctone_ctrl_o  = converter_tone_control;

endmodule

// ### hdl/aapc_defs.vh
// Register offsets, field positions and reset values of the audio converter control block
`ifndef AAPC_DEFS_VH
`define AAPC_DEFS_VH

// ==========================================================================
// Register byte offsets
`define AAPC_OFS_FE_EN        12'h010
`define AAPC_OFS_SER_OUT      12'h034
`define AAPC_OFS_DL_SRC       12'h108
`define AAPC_OFS_UL_SRC       12'h114
`define AAPC_OFS_UL_MUX       12'h118
`define AAPC_OFS_TOP          12'h120
`define AAPC_OFS_IF_EN        12'h124
`define AAPC_OFS_TONE_GEN     12'h1F0
`define AAPC_OFS_PATH_EN      12'hF00
`define AAPC_OFS_RATE         12'hF04
`define AAPC_OFS_TEST         12'hF08
`define AAPC_OFS_LOFS         12'hF0C
`define AAPC_OFS_ROFS         12'hF10
`define AAPC_OFS_CTONE        12'hF20
`define AAPC_OFS_DCC_EN       12'hF28
`define AAPC_OFS_UPDATE       12'hF2C
`define AAPC_OFS_STATUS       12'hF30

// ==========================================================================
// Field positions
`define AAPC_PATH_DL_BIT      0
`define AAPC_PATH_UL_BIT      1
`define AAPC_REC_RATE_HI      20
`define AAPC_REC_RATE_LO      19
`define AAPC_REC_RATE2_HI     18
`define AAPC_REC_RATE2_LO     17
`define AAPC_UL_MUX_BIT       27
`define AAPC_TG_TONE_ON_BIT   26
`define AAPC_TG_MUTE2_BIT     25
`define AAPC_TG_MUTE1_BIT     24
`define AAPC_DL_VOICE_BIT     5
`define AAPC_DL_GAIN_BIT      1
`define AAPC_TOP_LOOP_HI      15
`define AAPC_TOP_LOOP_LO      12
`define AAPC_SO_FS_HI         11
`define AAPC_SO_FS_LO         8
`define AAPC_SO_I2S_BIT       3
`define AAPC_SO_W32_BIT       1
`define AAPC_RATE_UL_BIT      4
`define AAPC_TEST_LMUTE_BIT   11
`define AAPC_TEST_RMUTE_BIT   10
`define AAPC_TEST_SWAP_BIT    8
`define AAPC_TEST_LOOP_BIT    3
`define AAPC_TEST_TONE_BIT    1
`define AAPC_CT_ON_BIT        15
`define AAPC_CT_DL_BIT        12
`define AAPC_UPD_DCC_BIT      9
`define AAPC_UPD_RATE_BIT     8
`define AAPC_LOOP_SINE        4'h4

// ==========================================================================
// Reset values
`define AAPC_RST_32           32'h0000_0000
`define AAPC_RST_16           16'h0000

`endif

// ### tb/aapc_ctrl_asserts.sv
// Concurrent checks on the ports of the audio converter control block
`timescale 1ns/10ps
module aapc_ctrl_asserts (
  input wire        clk_i,                // Clock
  input wire        rst_i,                // Sync reset
  input wire        wb_cyc_i,             // Bus cycle
  input wire        wb_stb_i,             // Bus strobe
  input wire        wb_we_i,              // Bus write
  input wire [11:0] wb_adr_i,             // Bus address
  input wire [3:0]  wb_sel_i,             // Byte lanes
  input wire [31:0] wb_dat_i,             // Write data
  input wire        wb_ack_o,             // Acknowledge
  input wire        wb_err_o,             // Unmapped answer
  input wire        dl_valid_i,           // Playback strobe in
  input wire        ul_valid_i,           // Record strobe in
  input wire        dl_valid_o,           // Playback strobe out
  input wire        ul_valid_o,           // Record strobe out
  input wire [15:0] dl_left_o,            // Playback left out
  input wire [3:0]  playback_rate_code_o, // Applied playback rate
  input wire        record_rate_code_o,   // Applied record rate
  input wire [15:0] test_ctrl_o,          // Test control copy
  input wire [31:0] ser_ctrl_o,           // Serial control copy
  input wire        playback_path_on_o,   // Playback live
  input wire        record_path_on_o      // Record live
);
  // ==========================================================================
  // Decoded bus requests, writes and address hits
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire wr  = wb_cyc_i && wb_stb_i && wb_we_i;
  wire upd = wr && wb_adr_i == 12'hF2C && wb_sel_i[1] && wb_dat_i[8];
  wire tst = wr && wb_adr_i == 12'hF08;
  wire sow = wr && wb_adr_i == 12'h034;
  wire hit = wb_adr_i inside {12'h010, 12'h034, 12'h108, 12'h114, 12'h118,
    12'h120, 12'h124, 12'h1F0, 12'hF00, 12'hF04, 12'hF08, 12'hF0C, 12'hF10,
    12'hF20, 12'hF28, 12'hF2C, 12'hF30};

  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_latency_a: assert property (req |=> (wb_ack_o || wb_err_o) ##1
    !(wb_ack_o || wb_err_o)) else $error("bus answer late or too long");
  unmapped_err_a: assert property (req && !hit |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  dl_gate_a: assert property (dl_valid_i && !playback_path_on_o |=>
    !dl_valid_o) else $error("playback sample passed while off");
  dl_pass_a: assert property (dl_valid_i && playback_path_on_o |=>
    dl_valid_o) else $error("playback sample dropped");
  ul_pass_a: assert property (ul_valid_i && record_path_on_o &&
    !test_ctrl_o[3] |=> ul_valid_o) else $error("record sample dropped");
  ul_gate_a: assert property (!record_path_on_o |=> !ul_valid_o)
    else $error("record sample passed while off");
  rate_hold_a: assert property ($changed(playback_rate_code_o) ||
    $changed(record_rate_code_o) |-> $past(upd, 1) || $past(upd, 2))
    else $error("rate applied without update");
  dl_hold_a: assert property (!dl_valid_o |-> $stable(dl_left_o))
    else $error("playback data moved without strobe");
  test_write_a: assert property ($changed(test_ctrl_o) |->
    $past(tst, 1) || $past(tst, 2)) else $error("test control moved alone");
  ser_write_a: assert property ($changed(ser_ctrl_o) |->
    $past(sow, 1) || $past(sow, 2)) else $error("serial control moved alone");
endmodule

bind aapc_ctrl aapc_ctrl_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_err_o,
  .dl_valid_i, .ul_valid_i, .dl_valid_o, .ul_valid_o, .dl_left_o,
  .playback_rate_code_o, .record_rate_code_o, .test_ctrl_o, .ser_ctrl_o,
  .playback_path_on_o, .record_path_on_o);

// ### tb/aapc_conv_model.sv
// Behavioural ADC side of the converter: a stereo record sample source
`timescale 1ns/10ps
module aapc_conv_model (
  input  wire        clk_i,      // Clock
  input  wire        run_i,      // Produce samples while high
  output reg         ul_valid_o, // Sample strobe
  output reg  [15:0] ul_left_o,  // Left sample
  output reg  [15:0] ul_right_o, // Right sample
  output reg  [15:0] last_l_o,   // Last left sent
  output reg  [15:0] last_r_o    // Last right sent
);
  reg [1:0] phase = 2'h0;
  initial begin
    ul_valid_o = 1'b0;
    ul_left_o  = 16'h0000;
    ul_right_o = 16'h0000;
    last_l_o   = 16'h0100;
    last_r_o   = 16'hFEFF;
  end
  // One sample every four cycles; lines show inverted junk in between
  always @(posedge clk_i) begin
    phase <= phase + 2'h1;
    if (run_i && phase == 2'h3) begin
      ul_valid_o <= 1'b1;
      ul_left_o  <= last_l_o + 16'h0101;
      ul_right_o <= ~(last_l_o + 16'h0101);
      last_l_o   <= last_l_o + 16'h0101;
      last_r_o   <= ~(last_l_o + 16'h0101);
    end else begin
      ul_valid_o <= 1'b0;
      ul_left_o  <= ~last_l_o;
      ul_right_o <= ~last_r_o;
    end
  end
endmodule

// ### tb/audio_adda_path_control_bench.sv
// Self-checking bench for the audio converter control block
`timescale 1ns/10ps
module audio_adda_path_control_bench;
  reg         clk_i = 1'b0, rst_i = 1'b1, adc_run = 1'b0;
  reg         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  reg  [11:0] wb_adr_i = 12'h000;
  reg  [3:0]  wb_sel_i = 4'h0;
  reg  [31:0] wb_dat_i = 32'h0000_0000;
  reg         dl_valid_i = 1'b0;
  reg  [15:0] dl_left_i = 16'h0000, dl_right_i = 16'h0000;
  wire [31:0] wb_dat_o, ul_src, ul_mux, tone, dl_src, top, ser;
  wire        wb_ack_o, wb_err_o, dl_valid_o, ul_valid_o, ul_valid_i;
  wire        rec_rate, pb_on, rec_on;
  wire [15:0] dl_left_o, dl_right_o, ul_left_o, ul_right_o, ul_left_i;
  wire [15:0] ul_right_i, test, ctone, last_l, last_r;
  wire [3:0]  pb_rate;
  int         errors = 0, cmp_count = 0;
  logic [31:0] q;
  logic        e;

  always #5 clk_i = ~clk_i;

  aapc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .dl_valid_i(dl_valid_i),
    .dl_left_i(dl_left_i), .dl_right_i(dl_right_i), .dl_valid_o(dl_valid_o),
    .dl_left_o(dl_left_o), .dl_right_o(dl_right_o), .ul_valid_i(ul_valid_i),
    .ul_left_i(ul_left_i), .ul_right_i(ul_right_i), .ul_valid_o(ul_valid_o),
    .ul_left_o(ul_left_o), .ul_right_o(ul_right_o),
    .playback_rate_code_o(pb_rate), .record_rate_code_o(rec_rate),
    .ul_src_ctrl_o(ul_src), .ul_mux_ctrl_o(ul_mux), .tone_ctrl_o(tone),
    .dl_src_ctrl_o(dl_src), .top_ctrl_o(top), .ser_ctrl_o(ser),
    .test_ctrl_o(test), .ctone_ctrl_o(ctone),
    .playback_path_on_o(pb_on), .record_path_on_o(rec_on));

  aapc_conv_model u_conv (.clk_i(clk_i), .run_i(adc_run),
    .ul_valid_o(ul_valid_i), .ul_left_o(ul_left_i), .ul_right_o(ul_right_i),
    .last_l_o(last_l), .last_r_o(last_r));

  // ==========================================================================
  // Shared tasks
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, g);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask

  // Holds the request until ack or err is sampled, then releases it
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    e = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (n >= 20) begin
      errors++;
      print_verdict;
    end
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask

  task automatic ds(input logic [15:0] l, r);
    @(posedge clk_i);
    {dl_valid_i, dl_left_i, dl_right_i} <= {1'b1, l, r};
    @(posedge clk_i);
    dl_valid_i <= 1'b0;
    #1;
  endtask

  task automatic wu;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (ul_valid_o !== 1'b1 && n < 20);
    chk("record strobe", 1, ul_valid_o);
    if (ul_valid_o !== 1'b1)
      print_verdict;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    logic [11:0] al [17] = '{12'h010, 12'h034, 12'h108, 12'h114, 12'h118,
      12'h120, 12'h124, 12'h1F0, 12'hF00, 12'hF04, 12'hF08, 12'hF0C,
      12'hF10, 12'hF20, 12'hF28, 12'hF2C, 12'hF30};
    foreach (al[i]) begin
      wb(1'b0, al[i], 0, 4'hF);
      chk("reset value", 0, q);
    end
    for (int i = 0; i < 16; i++) wr(al[i], 32'hFFFF_FFFF);
    for (int i = 0; i < 16; i++) begin
      wb(1'b0, al[i], 0, 4'hF);
      chk("all ones", i < 8 ? 32'hFFFF_FFFF : 32'h0000_FFFF, q);
    end
    wr(12'hF30, 0);
    wb(1'b0, 12'hF30, 0, 4'hF);
    chk("status", 32'h0003_001F, q);
    for (int i = 0; i < 16; i++) wr(al[i], 0);
    wb(1'b1, 12'hF0C, 32'h1234_5678, 4'h1);
    wb(1'b0, 12'hF0C, 0, 4'hF);
    chk("lane merge", 32'h0000_0078, q);
    wb(1'b0, 12'h200, 0, 4'hF);
    chk("unmapped", 1, e);
    wr(12'h118, 32'h0800_0000);
    chk("ul mux", 32'h0800_0000, ul_mux);
    wr(12'h120, 32'h0000_4001);
    chk("top", 32'h0000_4001, top);
    $display("t_regs done");
  endtask

  task automatic t_up;
    logic [11:0] a [11] = '{12'h114, 12'h118, 12'h1F0, 12'h108, 12'h120,
      12'h034, 12'h124, 12'h010, 12'hF04, 12'hF08, 12'hF20};
    logic [31:0] d [11] = '{32'h001E_0001, 0, 32'h942E_A2E5, 32'h0300_1803,
      0, 32'h0000_000B, 1, 1, 32'h000A, 32'h000A, 32'h9010};
    foreach (a[i]) wr(a[i], d[i]);
    chk("ul src", 32'h001E_0001, ul_src);
    chk("tone gen", 32'h942E_A2E5, tone);
    chk("dl src", 32'h0300_1803, dl_src);
    chk("serial", 32'h0000_000B, ser);
    chk("test", 32'h000A, test);
    chk("ctone", 32'h9010, ctone);
    chk("stale rate", 32'hF, pb_rate);
    chk("pb off", 0, pb_on);
    wr(12'hF2C, 32'h0100);
    wr(12'hF2C, 32'h0000);
    chk("pb rate", 32'hA, pb_rate);
    chk("rec rate", 0, rec_rate);
    wr(12'hF00, 32'h0003);
    chk("pb on", 1, pb_on);
    chk("rec on", 1, rec_on);
    $display("t_up done");
  endtask

  task automatic t_samples;
    wr(12'hF08, 0);
    adc_run <= 1'b1;
    wu;
    chk("ul left", last_l, ul_left_o);
    wr(12'hF08, 32'h0100);
    wu;
    wu;
    chk("swap", last_r, ul_left_o);
    chk("swap right", last_l, ul_right_o);
    ds(16'h1234, 16'h5678);
    chk("dl left", 32'h1234, dl_left_o);
    wr(12'hF08, 32'h0800);
    ds(16'h1234, 16'h5678);
    chk("mute left", 0, dl_left_o);
    chk("right kept", 32'h5678, dl_right_o);
    wr(12'hF08, 32'h0008);
    ds(16'hABCD, 16'h5678);
    chk("loopback", 32'hABCD, ul_left_o);
    wr(12'hF08, 0);
    $display("t_samples done");
  endtask

  task automatic t_offset;
    wr(12'hF0C, 32'h0100);
    wr(12'hF10, 32'hFF00);
    wr(12'hF28, 32'h0001);
    ds(16'h7FF0, 16'h0010);
    chk("old left ofs", 32'h7FEF, dl_left_o);
    chk("old right ofs", 32'h000F, dl_right_o);
    wr(12'hF2C, 32'h0200);
    wr(12'hF2C, 0);
    ds(16'h7FF0, 16'h0010);
    chk("left sat", 32'h7FFF, dl_left_o);
    chk("right ofs", 32'hFF10, dl_right_o);
    wr(12'hF28, 0);
    ds(16'h7FF0, 16'h0010);
    chk("comp off", 32'h7FF0, dl_left_o);
    $display("t_offset done");
  endtask

  task automatic t_down;
    wr(12'h124, 0);
    chk("if off", 0, pb_on);
    ds(16'h1111, 16'h2222);
    chk("no strobe", 0, dl_valid_o);
    wr(12'h124, 1);
    chk("if on", 1, pb_on);
    wr(12'h010, 0);
    chk("fe off", 0, rec_on);
    wr(12'h010, 1);
    wr(12'hF00, 0);
    chk("paths off", 0, {pb_on, rec_on});
    wr(12'h124, 0);
    wr(12'h010, 0);
    $display("t_down done");
  endtask

  task automatic t_record;
    wr(12'h124, 1);
    wr(12'h010, 1);
    wr(12'hF04, 32'h0010);
    wr(12'hF2C, 32'h0100);
    wr(12'hF2C, 0);
    wr(12'hF00, 32'h0002);
    chk("rec only", 32'h1, {pb_on, rec_on});
    chk("rates", 32'h10, {rec_rate, pb_rate});
    wu;
    chk("ul left", last_l, ul_left_o);
    $display("t_record done");
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_up;
    t_samples;
    t_offset;
    t_down;
    t_record;
    print_verdict;
  end
endmodule
